// File: rtl/psl_mux_defs.vh
// constants for the peripheral select and lock mux block
`ifndef PSL_MUX_DEFS_VH
`define PSL_MUX_DEFS_VH
`define PSL_OFF_SELECT       12'h000
`define PSL_OFF_LOCK         12'h018
`define PSL_ADDR_W           12
`define PSL_UNLOCK_KEY       32'h10C0010C
`define PSL_SELECT_RESET     7'h06
`define PSL_SELECT_MASK      32'h0000007F
`define PSL_BIT_AUDIO        0
`define PSL_BIT_SERIAL_A     1
`define PSL_BIT_SERIAL_B     2
`define PSL_BIT_TWO_WIRE     3
`define PSL_BIT_VIDEO_A      4
`define PSL_BIT_VIDEO_B      5
`define PSL_BIT_VIDEO_C      6
`endif

// File: rtl/psl_pin_group.v
// one shared pin group: steers pins between video data and an alternate function
`timescale 1ns/10ps
module psl_pin_group #(
  parameter W = 8
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         alt_sel_i,
  input  wire         video_en_i,
  input  wire [W-1:0] video_out_i,
  input  wire [W-1:0] video_oe_i,
  input  wire [W-1:0] alt_out_i,
  input  wire [W-1:0] alt_oe_i,
  output reg  [W-1:0] pin_out_o,
  output reg  [W-1:0] pin_oe_o,
  output reg          video_live_o,
  output reg          alt_live_o
);
  // registered steering; pins float while neither owner is live
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o    <= {W{1'b0}};
      pin_oe_o     <= {W{1'b0}};
      video_live_o <= 1'b0;
      alt_live_o   <= 1'b0;
    end else begin
      alt_live_o   <= alt_sel_i;
      video_live_o <= ~alt_sel_i & video_en_i;
      if (alt_sel_i) begin
        pin_out_o <= alt_out_i;
        pin_oe_o  <= alt_oe_i;
      end else if (video_en_i) begin
        pin_out_o <= video_out_i;
        pin_oe_o  <= video_oe_i;
      end else begin
        pin_out_o <= {W{1'b0}};
        pin_oe_o  <= {W{1'b0}};
      end
    end
  end
endmodule // psl_pin_group

// File: rtl/psl_mux.v
// peripheral select register, key lock and shared pin steering
//
// How it works
// - bit 5 enables video port b
// - bit 4 enables video port a
// - bit 3 enables two-wire controller
// - bit 2 gives port b low pins serial
// - bit 1 gives port a low pins serial
// - bit 0 gives upper pins to audio
// - low pins ignore the audio select
// - low pins carry buffered serial signals
// - upper pins carry audio clocks and lanes
// - serial ports a and b selected after power-up, all else disabled
// - key write unlocks the select register
// - lock register reads lock status bit
// - locked writes leave selection unchanged
// - any select write relocks
// - locked after reset
// - bit 6 enables video port c
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`include "psl_mux_defs.vh"
module psl_mux #(
  parameter LOW_W = 7,
  parameter UP_W  = 8
) (
  input  wire             clk_i,
  input  wire             rst_i,
  // ahb-lite slave
  input  wire             hsel_i,
  input  wire [31:0]      haddr_i,
  input  wire [1:0]       htrans_i,
  input  wire             hwrite_i,
  input  wire [2:0]       hsize_i,
  input  wire             hready_i,
  input  wire [31:0]      hwdata_i,
  output reg  [31:0]      hrdata_o,
  output reg              hreadyout_o,
  output reg              hresp_o,
  // peripheral enables
  output reg              video_port_a_enable_o,
  output reg              video_port_b_enable_o,
  output reg              video_port_c_enable_o,
  output reg              two_wire_ctrl_enable_o,
  output reg              serial_port_a_select_o,
  output reg              serial_port_b_select_o,
  output reg              audio_port_select_o,
  // port a low group: video data 8..2 or serial port a
  input  wire [LOW_W-1:0] vid_a_low_out_i,
  input  wire [LOW_W-1:0] vid_a_low_oe_i,
  input  wire [LOW_W-1:0] ser_a_out_i,
  input  wire [LOW_W-1:0] ser_a_oe_i,
  output wire [LOW_W-1:0] pin_a_low_out_o,
  output wire [LOW_W-1:0] pin_a_low_oe_o,
  output wire             vid_a_low_live_o,
  output wire             ser_a_live_o,
  // port b low group: video data 8..2 or serial port b
  input  wire [LOW_W-1:0] vid_b_low_out_i,
  input  wire [LOW_W-1:0] vid_b_low_oe_i,
  input  wire [LOW_W-1:0] ser_b_out_i,
  input  wire [LOW_W-1:0] ser_b_oe_i,
  output wire [LOW_W-1:0] pin_b_low_out_o,
  output wire [LOW_W-1:0] pin_b_low_oe_o,
  output wire             vid_b_low_live_o,
  output wire             ser_b_live_o,
  // port a upper group: video data 19..12 or audio clocks, frames, mutes
  input  wire [UP_W-1:0]  vid_a_up_out_i,
  input  wire [UP_W-1:0]  vid_a_up_oe_i,
  input  wire [UP_W-1:0]  audio_ctl_out_i,
  input  wire [UP_W-1:0]  audio_ctl_oe_i,
  output wire [UP_W-1:0]  pin_a_up_out_o,
  output wire [UP_W-1:0]  pin_a_up_oe_o,
  output wire             vid_a_up_live_o,
  output wire             audio_ctl_live_o,
  // port b upper group: video data 19..12 or audio serial lanes
  input  wire [UP_W-1:0]  vid_b_up_out_i,
  input  wire [UP_W-1:0]  vid_b_up_oe_i,
  input  wire [UP_W-1:0]  audio_serial_lanes_out_i,
  input  wire [UP_W-1:0]  audio_serial_lanes_oe_i,
  output wire [UP_W-1:0]  pin_b_up_out_o,
  output wire [UP_W-1:0]  pin_b_up_oe_o,
  output wire             vid_b_up_live_o,
  output wire             audio_lanes_live_o
);

  localparam [1:0] HTRANS_NONSEQ = 2'h2;
  localparam [1:0] HTRANS_SEQ    = 2'h3;

  reg  [6:0]  select_q;
  reg  [6:0]  select_d;
  reg         locked_q;
  reg         locked_d;
  reg         wr_pend_q;
  reg  [11:0] wr_addr_q;
  wire        addr_ok;
  wire        take;
  wire [31:0] sel_word;
  wire [31:0] lock_word;

  // address phase accepted on any nonseq or seq while the bus is ready
  assign take    = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
  assign addr_ok = (haddr_i[31:`PSL_ADDR_W] == {(32-`PSL_ADDR_W){1'b0}});

  // bus timing, as seen by a master on this slave
  //   edge n   : address phase taken, read data launched
  //   edge n+1 : write data taken, select and lock move
  //   edge n+2 : enable outputs and pin groups follow
  // reads launch at the address edge so no wait state is needed;
  // a write just before a read is forwarded through select_d and
  // locked_d, so a read back never shows stale contents
  // unmapped addresses: writes dropped, reads give zero, still okay

  // capture the address phase for the following data phase
  // only writes need it; reads are answered straight from the address phase
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= take & hwrite_i & addr_ok;
      wr_addr_q <= haddr_i[11:0];
    end
  end

  // select register and lock update during write data phase
  always @* begin
    select_d = select_q;
    locked_d = locked_q;
    if (wr_pend_q && wr_addr_q == `PSL_OFF_SELECT) begin
      if (!locked_q) begin
        select_d = hwdata_i[6:0];
      end
      locked_d = 1'b1;
    end else if (wr_pend_q && wr_addr_q == `PSL_OFF_LOCK) begin
      if (hwdata_i == `PSL_UNLOCK_KEY) begin
        locked_d = 1'b0;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      select_q <= `PSL_SELECT_RESET;
      locked_q <= 1'b1;
    end else begin
      select_q <= select_d;
      locked_q <= locked_d;
    end
  end

  assign sel_word  = {25'h0000000, select_q};
  assign lock_word = {31'h00000000, locked_q};

  // read data registered from the address phase, zero wait states
  always @(posedge clk_i) begin
    if (rst_i) begin
      hrdata_o    <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (take && !hwrite_i && addr_ok && haddr_i[11:0] == `PSL_OFF_SELECT) begin
        hrdata_o <= {25'h0000000, select_d};
      end else if (take && !hwrite_i && addr_ok && haddr_i[11:0] == `PSL_OFF_LOCK) begin
        hrdata_o <= {31'h00000000, locked_d};
      end else begin
        hrdata_o <= 32'h00000000;
      end
    end
  end

  // enable outputs straight from flops, one cycle behind the register
  always @(posedge clk_i) begin
    if (rst_i) begin
      video_port_a_enable_o  <= 1'b0;
      video_port_b_enable_o  <= 1'b0;
      video_port_c_enable_o  <= 1'b0;
      two_wire_ctrl_enable_o <= 1'b0;
      serial_port_a_select_o <= 1'b1;
      serial_port_b_select_o <= 1'b1;
      audio_port_select_o    <= 1'b0;
    end else begin
      video_port_b_enable_o  <= select_q[`PSL_BIT_VIDEO_B];
      video_port_a_enable_o  <= select_q[`PSL_BIT_VIDEO_A];
      video_port_c_enable_o  <= select_q[`PSL_BIT_VIDEO_C];
      two_wire_ctrl_enable_o <= select_q[`PSL_BIT_TWO_WIRE];
      serial_port_a_select_o <= select_q[`PSL_BIT_SERIAL_A];
      serial_port_b_select_o <= select_q[`PSL_BIT_SERIAL_B];
      audio_port_select_o    <= select_q[`PSL_BIT_AUDIO];
    end
  end

  // low group bit order, msb first (data pins 8 down to 2):
  //   bit 6 receive clock
  //   bit 5 receive frame
  //   bit 4 receive data
  //   bit 3 source clock
  //   bit 2 transmit data
  //   bit 1 transmit frame
  //   bit 0 transmit clock
  // port a upper group bit order (data pins 19 down to 12):
  //   bit 7 transmit high-speed clock
  //   bit 6 transmit frame sync
  //   bit 5 transmit bit clock
  //   bit 4 mute out
  //   bit 3 mute in
  //   bit 2 receive high-speed clock
  //   bit 1 receive frame sync
  //   bit 0 receive bit clock
  // port b upper group: audio serial lanes 7..0 on data pins 19..12
  // a switch between owners lands on one edge for all pins of a group,
  // so no pin is ever driven by both functions in the same cycle

  // port a low pins to serial
  psl_pin_group #(.W(LOW_W)) u_low_a (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .alt_sel_i    (select_q[`PSL_BIT_SERIAL_A]),
    .video_en_i   (select_q[`PSL_BIT_VIDEO_A]),
    .video_out_i  (vid_a_low_out_i),
    .video_oe_i   (vid_a_low_oe_i),
    .alt_out_i    (ser_a_out_i),
    .alt_oe_i     (ser_a_oe_i),
    .pin_out_o    (pin_a_low_out_o),
    .pin_oe_o     (pin_a_low_oe_o),
    .video_live_o (vid_a_low_live_o),
    .alt_live_o   (ser_a_live_o)
  );

  // port b low pins to serial
  psl_pin_group #(.W(LOW_W)) u_low_b (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .alt_sel_i    (select_q[`PSL_BIT_SERIAL_B]),
    .video_en_i   (select_q[`PSL_BIT_VIDEO_B]),
    .video_out_i  (vid_b_low_out_i),
    .video_oe_i   (vid_b_low_oe_i),
    .alt_out_i    (ser_b_out_i),
    .alt_oe_i     (ser_b_oe_i),
    .pin_out_o    (pin_b_low_out_o),
    .pin_oe_o     (pin_b_low_oe_o),
    .video_live_o (vid_b_low_live_o),
    .alt_live_o   (ser_b_live_o)
  );

  // audio control on port a upper
  psl_pin_group #(.W(UP_W)) u_up_a (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .alt_sel_i    (select_q[`PSL_BIT_AUDIO]),
    .video_en_i   (select_q[`PSL_BIT_VIDEO_A]),
    .video_out_i  (vid_a_up_out_i),
    .video_oe_i   (vid_a_up_oe_i),
    .alt_out_i    (audio_ctl_out_i),
    .alt_oe_i     (audio_ctl_oe_i),
    .pin_out_o    (pin_a_up_out_o),
    .pin_oe_o     (pin_a_up_oe_o),
    .video_live_o (vid_a_up_live_o),
    .alt_live_o   (audio_ctl_live_o)
  );

  // audio lanes on port b upper
  psl_pin_group #(.W(UP_W)) u_up_b (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .alt_sel_i    (select_q[`PSL_BIT_AUDIO]),
    .video_en_i   (select_q[`PSL_BIT_VIDEO_B]),
    .video_out_i  (vid_b_up_out_i),
    .video_oe_i   (vid_b_up_oe_i),
    .alt_out_i    (audio_serial_lanes_out_i),
    .alt_oe_i     (audio_serial_lanes_oe_i),
    .pin_out_o    (pin_b_up_out_o),
    .pin_oe_o     (pin_b_up_oe_o),
    .video_live_o (vid_b_up_live_o),
    .alt_live_o   (audio_lanes_live_o)
  );

endmodule // psl_mux

// File: verification/psl_mux_asserts.sv
// assertion checker for the peripheral select and lock mux
`timescale 1ns/10ps
`include "psl_mux_defs.vh"
module psl_mux_asserts #(
  parameter LOW_W = 7,
  parameter UP_W  = 8
) (
  input wire             clk_i, rst_i, hsel_i, hwrite_i, hready_i,
  input wire [31:0]      haddr_i, hwdata_i, hrdata_o,
  input wire [1:0]       htrans_i,
  input wire             video_port_a_enable_o, video_port_b_enable_o, video_port_c_enable_o, two_wire_ctrl_enable_o,
  input wire             serial_port_a_select_o, serial_port_b_select_o, audio_port_select_o, ser_a_live_o,
  input wire [LOW_W-1:0] ser_a_oe_i, vid_a_low_oe_i, pin_a_low_oe_o
);
  reg         dp_q;
  reg  [31:0] adr_q;
  reg         lk_q;
  reg  [6:0]  sel_q;
  wire [6:0]  en_v = {video_port_c_enable_o, video_port_b_enable_o, video_port_a_enable_o, two_wire_ctrl_enable_o,
                      serial_port_b_select_o, serial_port_a_select_o, audio_port_select_o};
  wire        take = hsel_i & hready_i & htrans_i[1];
  wire        wr_sel = dp_q && adr_q == {20'h0, `PSL_OFF_SELECT};
  wire        wr_key = dp_q && adr_q == {20'h0, `PSL_OFF_LOCK} && hwdata_i == `PSL_UNLOCK_KEY;
  wire        rd_lock = take && !hwrite_i && haddr_i == {20'h0, `PSL_OFF_LOCK};
  wire        rd_sel = take && !hwrite_i && haddr_i == {20'h0, `PSL_OFF_SELECT};

  // reference lock and selection, moved at the edge that takes write data
  always @(posedge clk_i) begin
    if (rst_i) begin
      dp_q  <= 1'b0;
      lk_q  <= 1'b1;
      sel_q <= `PSL_SELECT_RESET;
    end else begin
      dp_q  <= take & hwrite_i;
      adr_q <= haddr_i;
      if (wr_key)
        lk_q <= 1'b0;
      else if (wr_sel)
        lk_q <= 1'b1;
      if (wr_sel && !lk_q)
        sel_q <= hwdata_i[6:0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_enable_track:
    assert property (en_v == $past(sel_q)) else $error("enables differ from selection");
  a_unlock_write:
    assert property (wr_sel && !lk_q |-> ##2 en_v == $past(hwdata_i[6:0], 2)) else $error("unlocked write lost");
  a_locked_hold:
    assert property (wr_sel && lk_q |-> ##2 $stable(en_v)) else $error("locked write changed enables");
  a_lock_read:
    assert property (rd_lock |=> hrdata_o == {31'h0, lk_q}) else $error("lock status read wrong");
  a_select_read:
    assert property (rd_sel |=> hrdata_o == {25'h0, sel_q}) else $error("selection read wrong");
  a_reset_state:
    assert property ($fell(rst_i) |-> en_v == `PSL_SELECT_RESET) else $error("enables wrong after reset");
  a_low_steer:
    assert property (!$past(rst_i) |-> pin_a_low_oe_o == (serial_port_a_select_o ? $past(ser_a_oe_i) :
      video_port_a_enable_o ? $past(vid_a_low_oe_i) : {LOW_W{1'b0}})) else $error("low pins misrouted");
  a_low_audio_free:
    assert property ($changed(audio_port_select_o) && $stable(serial_port_a_select_o) |-> $stable(ser_a_live_o))
      else $error("audio select moved low pins");

  // main scenarios reached
  c_locked_write: cover property (wr_sel && lk_q);
  c_unlocked_read: cover property (rd_lock && !lk_q);
  c_audio_pins: cover property (audio_port_select_o && !serial_port_a_select_o);
endmodule // psl_mux_asserts

bind psl_mux psl_mux_asserts #(.LOW_W(LOW_W), .UP_W(UP_W)) u_psl_mux_asserts (.*);

// File: verification/test_peripheral_select_lock_mux.sv
// self-checking bench for the peripheral select and lock mux
`timescale 1ns/10ps
`include "psl_mux_defs.vh"
module test_peripheral_select_lock_mux;
  localparam [31:0] SEL_A  = {20'h0, `PSL_OFF_SELECT};
  localparam [31:0] LOCK_A = {20'h0, `PSL_OFF_LOCK};
  localparam [31:0] KEY    = `PSL_UNLOCK_KEY;
  reg          clk_i = 1'b0;
  reg          rst_i = 1'b1;
  reg          hsel_i = 1'b0;
  reg          hwrite_i = 1'b0;
  reg  [1:0]   htrans_i = 2'h0;
  reg  [31:0]  haddr_i = 32'h0;
  reg  [31:0]  hwdata_i = 32'h0;
  reg  [7:0]   pa = 8'h00;
  wire [7:0]   pb = ~pa;
  wire [31:0]  hrdata_o;
  wire         hreadyout_o;
  wire [6:0]   en_v;
  wire [7:0]   live_v;
  wire [7:0]   up_b_pin;
  wire         hresp_o;
  logic [31:0] s;
  logic [7:0]  ev;
  logic [7:0]  ep;
  logic [31:0] rd;
  int          n_fail = 0;
  int          tests_run = 0;
  // value written and selection expected back
  logic [31:0] rows [6][2] = '{'{32'h7F, 32'h7F}, '{32'hFFFFFF80, 32'h00}, '{32'h01, 32'h01},
                              '{32'h4C, 32'h4C}, '{32'h06, 32'h06}, '{32'h32, 32'h32}};

  always #25 clk_i = ~clk_i;
  // moving function-side drive so steering faults show
  always @(posedge clk_i) pa <= pa + 8'h01;

  psl_mux u_psl_mux (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .audio_port_select_o(en_v[0]), .serial_port_a_select_o(en_v[1]),
    .serial_port_b_select_o(en_v[2]),
    .two_wire_ctrl_enable_o(en_v[3]), .video_port_a_enable_o(en_v[4]), .video_port_b_enable_o(en_v[5]),
    .video_port_c_enable_o(en_v[6]), .vid_a_low_out_i(pa[6:0]), .vid_a_low_oe_i(pa[7:1]), .ser_a_out_i(pb[6:0]),
    .ser_a_oe_i(pb[7:1]), .pin_a_low_out_o(), .pin_a_low_oe_o(), .vid_a_low_live_o(live_v[1]),
    .ser_a_live_o(live_v[0]),
    .vid_b_low_out_i(pb[7:1]), .vid_b_low_oe_i(pa[6:0]), .ser_b_out_i(pa[7:1]), .ser_b_oe_i(pb[6:0]),
    .pin_b_low_out_o(), .pin_b_low_oe_o(), .vid_b_low_live_o(live_v[3]), .ser_b_live_o(live_v[2]),
    .vid_a_up_out_i(pa),
    .vid_a_up_oe_i(pb), .audio_ctl_out_i(pb), .audio_ctl_oe_i(pa), .pin_a_up_out_o(), .pin_a_up_oe_o(),
    .vid_a_up_live_o(live_v[5]), .audio_ctl_live_o(live_v[4]), .vid_b_up_out_i(pa), .vid_b_up_oe_i(pa),
    .audio_serial_lanes_out_i(pb),
    .audio_serial_lanes_oe_i(pb), .pin_b_up_out_o(up_b_pin), .pin_b_up_oe_o(), .vid_b_up_live_o(live_v[7]),
    .audio_lanes_live_o(live_v[6])
  );

  // single word transfer; ready looked at mid-cycle so the edge never races
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    begin
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      hwrite_i <= w;
      haddr_i <= a;
      do @(negedge clk_i); while (hreadyout_o !== 1'b1);
      @(posedge clk_i);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(negedge clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
      @(posedge clk_i);
    end
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      tests_run++;
      if (g !== e) begin
        n_fail++;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // hang guard, far beyond the roughly 90 cycles needed
  initial begin
    #100000;
    n_fail++;
    end_sim;
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("enables", 32'h06, {25'h0, en_v});
    bus(1'b0, SEL_A, 32'h0);
    chk("select", 32'h06, rd);
    bus(1'b0, LOCK_A, 32'h0);
    chk("lock", 32'h1, rd);
    $display("reset test done");
    bus(1'b1, SEL_A, 32'h7F);
    bus(1'b1, LOCK_A, KEY ^ 32'h1);
    bus(1'b1, SEL_A, 32'h7F);
    bus(1'b0, SEL_A, 32'h0);
    chk("locked select", 32'h06, rd);
    bus(1'b0, LOCK_A, 32'h0);
    chk("lock after bad key", 32'h1, rd);
    bus(1'b1, LOCK_A, KEY);
    bus(1'b0, LOCK_A, 32'h0);
    chk("lock after key", 32'h0, rd);
    $display("lock test done");
    // each row: unlock, write, confirm relock, read back, see enables
    // function-side drive keeps counting through every row, so pins
    // switch while values move, and upper b pins are checked against that drive
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, LOCK_A, KEY);
      bus(1'b1, SEL_A, rows[i][0]);
      bus(1'b0, LOCK_A, 32'h0);
      chk("relock", 32'h1, rd);
      bus(1'b0, SEL_A, 32'h0);
      chk("select", rows[i][1], rd);
      chk("enables", rows[i][1], {25'h0, en_v});
      s = rows[i][1];
      ev = {~s[0] & s[5], s[0], ~s[0] & s[4], s[0], ~s[2] & s[5], s[2], ~s[1] & s[4], s[1]};
      chk("live groups", {24'h0, ev}, {24'h0, live_v});
      @(negedge clk_i);
      ep = s[0] ? ~(pa - 8'h01) : (s[5] ? pa - 8'h01 : 8'h00);
      chk("upper b pins", {24'h0, ep}, {24'h0, up_b_pin});
      chk("response", 32'h0, {31'h0, hresp_o});
      @(posedge clk_i);
    end
    $display("row test done");
    bus(1'b0, 32'h00000100, 32'h0);
    chk("unmapped", 32'h0, rd);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, SEL_A, 32'h0);
    chk("select after reset", 32'h06, rd);
    $display("second reset test done");
    end_sim;
  end
endmodule // test_peripheral_select_lock_mux
